/* File: shared/bmd_consts.svh */
/*
  Constants for the bus style personality block: lane masks, settle count.
  Assumes inclusion by bare name from the design file.
*/
`ifndef BMD_CONSTS_SVH
`define BMD_CONSTS_SVH

`define BMD_LANES_NONE 32'h0000_0000
`define BMD_LANES_LOW 32'h0000_FFFF
`define BMD_LANES_ALL 32'hFFFF_FFFF
`define BMD_STRAP_SETTLE 2'h3
`define BMD_STYLE_BIG 1'b1
`define BMD_STYLE_LITTLE 1'b0

`endif

/* File: shared/bmd_pkg.sv */
/*
  Types for the bus style personality block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bmd_pkg;
  typedef enum logic [2:0] {
    BMD_IDLE = 3'b000,
    BMD_REQ  = 3'b001,
    BMD_ADDR = 3'b010,
    BMD_WAIT = 3'b011,
    BMD_DONE = 3'b100
  } bmd_state_t;
endpackage

/* File: src/bmd_bus_personality.sv */
/*
  Bus style personality: strap capture, dual-meaning control pins, master
  cycle sequencer, data lane steering, byte order and interrupt polarity.
  Assumes core logic on sys_clk drives the mst_, slv_ and irq_ inputs; all
  pin inputs are asynchronous and two-way pins are resolved outside.
*/
// Notes on behaviour
// - Strap high gives big-endian order and the first meaning of each control pin.
// - Strap low gives little-endian order and the second meaning of each control pin.
// - The strap picks strobe, direction, interrupt, request, grant, slave and ack meanings.
// - As master, 16-bit words use only data lines 15 to 0.
// - As master, 32-bit words use all data lines 31 to 0.
// - A slave register read drives only data lines 15 to 0.
// - Big style: strobe falls for valid address and rises to end; little: rise marks it.
// - Memory direction is high for read in big style and low for read in little style.
// - Interrupt is active low in big style, high in little, and only for enabled sources.
`timescale 1ns/100ps
`include "bmd_consts.svh"

module bmd_bus_personality #(
  parameter int IRQ_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic bus_style_select,
  input wire logic bus_grant_i,
  input wire logic slave_dir_i,
  input wire logic ack_lane0_i,
  input wire logic ack_lane1_i,
  input wire logic [31:0] system_data_lines_i,
  input wire logic mst_req,
  input wire logic mst_write,
  input wire logic mst_wide,
  input wire logic [31:0] mst_wdata,
  input wire logic slv_sel,
  input wire logic [15:0] slv_rdata,
  input wire logic [IRQ_W-1:0] irq_pend,
  input wire logic [IRQ_W-1:0] irq_mask,
  output logic style_big,
  output logic style_valid,
  output logic cycle_strobe_o,
  output logic cycle_strobe_oe,
  output logic mem_dir_o,
  output logic mem_dir_oe,
  output logic bus_request_o,
  output logic ready_out_o,
  output logic ready_out_oe,
  output logic irq_o,
  output logic irq_oe,
  output logic [31:0] system_data_lines_o,
  output logic [31:0] system_data_lines_oe,
  output logic [31:0] mst_rdata,
  output logic mst_done
);
  if (IRQ_W < 1) begin : g_irq_w_check
    $error("IRQ_W must be at least 1");
  end

  // Byte order of one 16-bit half: big style swaps the two byte lanes
  function automatic logic [15:0] ord16(input logic big, input logic [15:0] x);
    ord16 = big ? {x[7:0], x[15:8]} : x;
  endfunction

  // Two-flop synchronisers for every pin input
  logic [4:0] pin_s1_q, pin_s2_q;
  logic [31:0] dat_s1_q, dat_s2_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 5'h00;
      pin_s2_q <= 5'h00;
      dat_s1_q <= 32'h0000_0000;
      dat_s2_q <= 32'h0000_0000;
    end else begin
      pin_s1_q <= {bus_style_select, bus_grant_i, slave_dir_i, ack_lane1_i, ack_lane0_i};
      pin_s2_q <= pin_s1_q;
      dat_s1_q <= system_data_lines_i;
      dat_s2_q <= dat_s1_q;
    end
  end

  wire strap_s = pin_s2_q[4];
  wire grant_s = pin_s2_q[3];
  wire sdir_s = pin_s2_q[2];
  wire ack1_s = pin_s2_q[1];
  wire ack0_s = pin_s2_q[0];

  // Strap is caught once after reset release, once the synchroniser has settled
  logic [1:0] settle_q;
  logic style_q, style_ok_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_q <= 2'h0;
      style_q <= `BMD_STYLE_LITTLE;
      style_ok_q <= 1'b0;
    end else if (!style_ok_q) begin
      settle_q <= settle_q + 2'h1;
      if (settle_q == `BMD_STRAP_SETTLE) begin
        style_q <= strap_s;
        style_ok_q <= 1'b1;
      end
    end
  end

  // Pin meanings chosen by the strap
  wire grant_act = style_q ? !grant_s : grant_s;
  wire ack_act = style_q ? (!ack0_s || !ack1_s) : !ack0_s;
  wire slave_read = slv_sel && (style_q ? sdir_s : !sdir_s);

  // Master cycle sequencer
  bmd_pkg::bmd_state_t st_q, st_d;
  logic wr_q, wide_q;
  logic [31:0] wdata_q;
  always_comb begin
    st_d = st_q;
    case (st_q)
      bmd_pkg::BMD_IDLE: begin
        if (mst_req && style_ok_q) st_d = bmd_pkg::BMD_REQ;
      end
      bmd_pkg::BMD_REQ: begin
        if (grant_act) st_d = bmd_pkg::BMD_ADDR;
      end
      bmd_pkg::BMD_ADDR: st_d = bmd_pkg::BMD_WAIT;
      bmd_pkg::BMD_WAIT: begin
        if (ack_act) st_d = bmd_pkg::BMD_DONE;
      end
      bmd_pkg::BMD_DONE: st_d = bmd_pkg::BMD_IDLE;
      default: st_d = bmd_pkg::BMD_IDLE;
    endcase
  end

  wire take_req = (st_q == bmd_pkg::BMD_IDLE) && (st_d == bmd_pkg::BMD_REQ);
  wire own_d = (st_d == bmd_pkg::BMD_ADDR) || (st_d == bmd_pkg::BMD_WAIT)
    || (st_d == bmd_pkg::BMD_DONE);
  wire drive_wr_d = wr_q && ((st_d == bmd_pkg::BMD_ADDR) || (st_d == bmd_pkg::BMD_WAIT));

  // Strobe: big holds low through the cycle and rises at the end; little pulses low
  wire strobe_d = style_q ? (st_d == bmd_pkg::BMD_DONE)
    : (st_d != bmd_pkg::BMD_ADDR);
  wire dir_d = style_q ? !wr_q : wr_q;
  wire req_d = style_q ? (st_d == bmd_pkg::BMD_IDLE) : (st_d != bmd_pkg::BMD_IDLE);

  // Data lane steering
  wire [31:0] wr_lanes = wide_q ? `BMD_LANES_ALL : `BMD_LANES_LOW;
  wire [31:0] oe_d = drive_wr_d ? wr_lanes
    : (slave_read ? `BMD_LANES_LOW : `BMD_LANES_NONE);
  wire [31:0] dout_d = drive_wr_d
    ? {ord16(style_q, wdata_q[31:16]), ord16(style_q, wdata_q[15:0])}
    : {16'h0000, ord16(style_q, slv_rdata)};
  wire [31:0] rd_d = wide_q
    ? {ord16(style_q, dat_s2_q[31:16]), ord16(style_q, dat_s2_q[15:0])}
    : {16'h0000, ord16(style_q, dat_s2_q[15:0])};

  // Interrupt: enabled sources only; polarity and driver type by style
  wire irq_act = |(irq_pend & irq_mask);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= bmd_pkg::BMD_IDLE;
      wr_q <= 1'b0;
      wide_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      if (take_req) begin
        wr_q <= mst_write;
        wide_q <= mst_wide;
        wdata_q <= mst_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cycle_strobe_o <= 1'b1;
      cycle_strobe_oe <= 1'b0;
      mem_dir_o <= 1'b0;
      mem_dir_oe <= 1'b0;
      bus_request_o <= 1'b0;
      system_data_lines_o <= 32'h0000_0000;
      system_data_lines_oe <= `BMD_LANES_NONE;
      mst_rdata <= 32'h0000_0000;
      mst_done <= 1'b0;
    end else begin
      cycle_strobe_o <= strobe_d;
      cycle_strobe_oe <= own_d;
      mem_dir_o <= dir_d;
      mem_dir_oe <= own_d;
      // Until the style is caught the pin rests at the strap's own idle level
      bus_request_o <= style_ok_q ? req_d : strap_s;
      system_data_lines_o <= dout_d;
      system_data_lines_oe <= oe_d;
      mst_done <= (st_d == bmd_pkg::BMD_DONE);
      if ((st_q == bmd_pkg::BMD_WAIT) && ack_act && !wr_q) mst_rdata <= rd_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      style_big <= 1'b0;
      style_valid <= 1'b0;
      ready_out_o <= 1'b1;
      ready_out_oe <= 1'b0;
      irq_o <= 1'b0;
      irq_oe <= 1'b0;
    end else begin
      style_big <= style_q;
      style_valid <= style_ok_q;
      ready_out_o <= !slave_read;
      ready_out_oe <= style_ok_q && !style_q;
      irq_o <= style_q ? 1'b0 : irq_act;
      irq_oe <= style_ok_q && (style_q ? irq_act : 1'b1);
    end
  end

  // Assertions
  wire drive_any = drive_wr_d || slave_read;
  sequence seq_grant;
    st_q == bmd_pkg::BMD_REQ && grant_act;
  endsequence
  sequence seq_addr_phase;
    (st_q == bmd_pkg::BMD_ADDR) ##1 (st_q == bmd_pkg::BMD_WAIT);
  endsequence

  style_locked_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    style_ok_q |=> $stable(style_q) && style_ok_q)
    else $error("strap style changed after capture");
  req_polarity_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    style_ok_q && $past(style_ok_q) |->
      bus_request_o == (style_q ? (st_q == bmd_pkg::BMD_IDLE) : (st_q != bmd_pkg::BMD_IDLE)))
    else $error("bus request polarity wrong for style");
  strobe_phase_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    seq_grant ##1 seq_addr_phase |->
      cycle_strobe_oe && (style_q ? !cycle_strobe_o : cycle_strobe_o)
      && !$past(cycle_strobe_o))
    else $error("address strobe edge wrong");
  strobe_end_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q == bmd_pkg::BMD_WAIT && ack_act |=>
      cycle_strobe_o && cycle_strobe_oe ##1 !cycle_strobe_oe)
    else $error("strobe did not end cycle");
  mem_dir_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mem_dir_oe |-> mem_dir_o == (style_q ? !wr_q : wr_q))
    else $error("memory direction polarity wrong");
  narrow_lanes_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q == bmd_pkg::BMD_WAIT && wr_q && !wide_q |-> system_data_lines_oe == `BMD_LANES_LOW)
    else $error("16-bit master write used upper lanes");
  wide_lanes_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q == bmd_pkg::BMD_WAIT && wr_q && wide_q |-> system_data_lines_oe == `BMD_LANES_ALL)
    else $error("32-bit master write missed lanes");
  slave_lanes_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_q == bmd_pkg::BMD_IDLE && slave_read |=>
      system_data_lines_oe == `BMD_LANES_LOW
      && system_data_lines_o[15:0] == ord16(style_q, $past(slv_rdata)))
    else $error("slave read lanes or byte order wrong");
  data_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    |system_data_lines_oe |-> $past(drive_any))
    else $error("data lines driven without cause");
  irq_level_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    style_ok_q && $past(style_ok_q) |->
      (style_q ? (irq_oe == $past(irq_act) && !irq_o) : (irq_oe && irq_o == $past(irq_act))))
    else $error("interrupt level wrong for style or mask");
endmodule

/* File: dv/bmd_host_model.sv */
/*
  Host side bus model: grants the bus on request and acknowledges master cycles.
  Assumes the personality block drives the request pin and strobe enable on sys_clk.
*/
`timescale 1ns/100ps
module bmd_host_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic big,
  input wire logic req_pin,
  input wire logic strobe_oe,
  input wire logic lane_sel,
  input wire logic [3:0] ack_wait,
  input wire logic [31:0] rd_word,
  output logic grant_pin,
  output logic ack0_pin,
  output logic ack1_pin,
  output logic [31:0] data_pin
);
  logic [3:0] cnt_q;
  logic ack_q;
  wire req_act = big ? ~req_pin : req_pin;
  // Big style acks on either lane; little style uses lane 0 as ready only
  assign ack0_pin = ~(ack_q & (~big | ~lane_sel));
  assign ack1_pin = ~(ack_q & big & lane_sel);
  // Outside a cycle the lines show the inverse so stale data never passes
  assign data_pin = strobe_oe ? rd_word : ~rd_word;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      grant_pin <= big;
      cnt_q <= 4'h0;
      ack_q <= 1'b0;
    end else begin
      grant_pin <= req_act ^ big;
      cnt_q <= strobe_oe ? cnt_q + 4'h1 : 4'h0;
      ack_q <= strobe_oe && (cnt_q >= ack_wait);
    end
  end
endmodule

/* File: dv/bmd_bus_personality_tb_top.sv */
/*
  Self-checking bench for the bus style personality block, both strap styles.
  Assumes the host model is compiled first and the design constants header is reachable.
*/
`timescale 1ns/100ps
module bmd_bus_personality_tb_top;
  typedef struct packed {
    logic [31:0] oe; logic [31:0] dat; logic [31:0] rd; logic dir; logic w;
  } bmd_exp_t;
  logic sys_clk = 1'b0, rst_n = 1'b0, style = 1'b1, sdir = 1'b0, lane = 1'b0;
  logic req = 1'b0, wr = 1'b0, wide = 1'b0, sel = 1'b0, seen = 1'b0;
  logic gnt, a0, a1, big, vld, stb, stb_oe, dir, dir_oe, breq, rdy, rdy_oe, irq, irq_oe, done;
  logic [3:0] wt = 4'h0;
  logic [31:0] wdat = 32'h0, rword = 32'h0, pin, d_o, d_oe, rdat;
  logic [15:0] srd = 16'h0, pend = 16'h0, mask = 16'h0;
  int seed = 32'h45dd, n_mismatch = 0, total_checks = 0;
  bmd_exp_t exq[$], cur;
  wire [31:0] d_wire = (d_oe & d_o) | (~d_oe & pin);

  bmd_bus_personality u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_style_select(style),
    .bus_grant_i(gnt), .slave_dir_i(sdir), .ack_lane0_i(a0), .ack_lane1_i(a1),
    .system_data_lines_i(d_wire), .mst_req(req), .mst_write(wr), .mst_wide(wide),
    .mst_wdata(wdat), .slv_sel(sel), .slv_rdata(srd), .irq_pend(pend), .irq_mask(mask),
    .style_big(big), .style_valid(vld), .cycle_strobe_o(stb), .cycle_strobe_oe(stb_oe),
    .mem_dir_o(dir), .mem_dir_oe(dir_oe), .bus_request_o(breq), .ready_out_o(rdy),
    .ready_out_oe(rdy_oe), .irq_o(irq), .irq_oe(irq_oe), .system_data_lines_o(d_o),
    .system_data_lines_oe(d_oe), .mst_rdata(rdat), .mst_done(done));
  bmd_host_model u_host (.sys_clk(sys_clk), .rst_n(rst_n), .big(style), .req_pin(breq),
    .strobe_oe(stb_oe), .lane_sel(lane), .ack_wait(wt), .rd_word(rword), .grant_pin(gnt),
    .ack0_pin(a0), .ack1_pin(a1), .data_pin(pin));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] ord(logic [31:0] x);
    return style ? {x[23:16], x[31:24], x[7:0], x[15:8]} : x;
  endfunction

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic mst(logic w, logic wd);
    logic [31:0] m;
    m = wd ? 32'hFFFF_FFFF : 32'h0000_FFFF;
    @(negedge sys_clk);
    wr = w;
    wide = wd;
    wdat = $random(seed);
    rword = $random(seed);
    wt = 4'($random(seed)) & 4'h3;
    lane = 1'($random(seed));
    exq.push_back('{w ? m : 32'h0, w ? ord(wdat) & m : 32'h0, ord(rword) & m, style ^ w, w});
    req = 1'b1;
    for (int i = 0; i < 60 && done !== 1'b1; i++) @(negedge sys_clk);
    req = 1'b0;
    chk("mst_done", 32'h1, 32'(done));
  endtask

  // Watches master cycles and compares each against the oldest note
  always @(negedge sys_clk) begin
    if (stb_oe === 1'b1 && seen !== 1'b1 && exq.size() > 0) begin
      cur = exq.pop_front();
      chk("data_oe", cur.oe, d_oe);
      chk("data_o", cur.dat, d_o & d_oe);
      chk("mem_dir", 32'(cur.dir), 32'(dir));
      chk("mem_dir_oe", 32'h1, 32'(dir_oe));
      chk("strobe", 32'h0, 32'(stb));
    end
    if (done === 1'b1) begin
      chk("strobe_end", 32'h1, 32'(stb));
      if (!cur.w) chk("rdata", cur.rd, rdat);
    end
    seen = stb_oe;
  end

  task automatic run_style(logic s);
    logic a;
    @(negedge sys_clk);
    rst_n = 1'b0;
    style = s;
    sdir = ~s;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 20 && vld !== 1'b1; i++) @(negedge sys_clk);
    chk("style_big", 32'(s), 32'(big));
    chk("idle_oe", 32'h0, d_oe);
    for (int i = 0; i < 6; i++) mst(i[0], i[1]);
    repeat (3) @(negedge sys_clk);
    chk("req_idle", 32'(s), 32'(breq));
    sdir = s;
    sel = 1'b1;
    srd = 16'($random(seed));
    repeat (5) @(negedge sys_clk);
    chk("slv_oe", 32'h0000_FFFF, d_oe);
    chk("slv_data", ord({16'h0, srd}), {16'h0, d_o[15:0]});
    chk("ready_oe", 32'(!s), 32'(rdy_oe));
    if (!s) chk("ready", 32'h0, 32'(rdy));
    sel = 1'b0;
    sdir = ~s;
    repeat (4) @(negedge sys_clk);
    chk("slv_release", 32'h0, d_oe);
    for (int i = 0; i < 6; i++) begin
      pend = 16'($random(seed));
      mask = (i == 0) ? 16'h0 : 16'($random(seed));
      repeat (2) @(negedge sys_clk);
      a = |(pend & mask);
      chk("irq_oe", 32'(s ? a : 1'b1), 32'(irq_oe));
      chk("irq_o", 32'(s ? 1'b0 : a), 32'(irq));
    end
  endtask

  initial begin
    run_style(1'b1);
    run_style(1'b0);
    finish_test();
  end

  // Both styles need well under a thousand cycles; this is ample margin
  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end
endmodule
